// ==== shared/adcf_pkg.sv ====
// shared constants and carriers for the serial conversion frame block
package adcf_pkg;
  localparam int unsigned RES_W           = 12;
  localparam int unsigned CNT_W           = 6;
  localparam int unsigned DIFF_W          = 14;
  // output codes of the straight binary transfer
  localparam logic [11:0] NEG_FULLSCALE   = 12'h000;
  localparam logic [11:0] MIDSCALE        = 12'h800;
  localparam logic [11:0] POS_FULLSCALE   = 12'hFFF;
  localparam logic [11:0] STORE_RESET     = 12'h000;
  // falling serial clock positions within a frame
  localparam logic [5:0]  CNT_ZERO        = 6'h00;
  localparam logic [5:0]  CNT_ONE         = 6'h01;
  localparam logic [5:0]  CNT_MAX         = 6'h3F;
  localparam logic [5:0]  DATA_FIRST_EDGE = 6'h02;
  localparam logic [5:0]  DATA_LAST_EDGE  = 6'h0D;
  localparam logic [5:0]  OUT_LOW_EDGE    = 6'h0E;
  localparam logic [5:0]  CAL_FIRST_EDGES = 6'h10;
  localparam logic [5:0]  CAL_START_EDGE  = 6'h11;
  localparam logic [5:0]  CAL_NORM_EDGES  = 6'h20;
  // timing, in ns, and derived counts at the system clock
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned ACQUISITION_WINDOW_NS        = 200;
  localparam int unsigned T_SETUP_NS      = 15;
  localparam int unsigned T_DESEL_NS      = 10;
  localparam int unsigned ACQ_CYC         = (ACQUISITION_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACQ_W           = 5;
  localparam logic [4:0]  ACQ_LAST        = 5'(ACQ_CYC - 1);
  localparam logic [4:0]  ACQ_ZERO        = 5'h00;

  // what the link logic hands back to the rest
  typedef struct packed {
    logic sdo;
    logic cal_done;
  } adcf_link_t;

  // state captured at the select falling edge
  typedef struct packed {
    logic              oe;
    logic              first;
    logic [RES_W-1:0]  word;
  } adcf_gate_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             sdo;
    logic             cal_done;
  } adcf_shift_t;

  typedef struct packed {
    logic              act_s1;
    logic              act_s2;
    logic              act_d;
    logic              cal_s1;
    logic              cal_s2;
    logic              cal_d;
    logic              pending;
    logic              loaded;
    logic [RES_W-1:0]  store;
    logic [RES_W-1:0]  hold;
    logic [ACQ_W-1:0]  acq_cnt;
    logic              ready;
  } adcf_top_t;
endpackage

// ==== rtl/adcf_frame_gate.sv ====
// select-edge capture: output enable, first-frame flag and the frame's result word
`timescale 1ns/1ps
module adcf_frame_gate (
  // frame select from the host
  input  wire logic                          cs_n,
  // quasi-static values from the system domain
  input  wire logic                          first_req,
  input  wire logic [adcf_pkg::RES_W-1:0]    word_in,
  // captured frame state
  output adcf_pkg::adcf_gate_t               gate
);
  adcf_pkg::adcf_gate_t st_r;
  adcf_pkg::adcf_gate_t st_nxt;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.oe    = 1'b1;
    st_nxt.first = first_req;
    st_nxt.word  = word_in;
  end

  // select is both clock and clear here: driving must start on the falling edge
  // itself and stop on the rising edge, with no serial clock present at either
  always_ff @(negedge cs_n or posedge cs_n) begin
    if (cs_n) begin
      st_r.oe <= 1'b0; // [RL7]
    end else begin
      st_r <= st_nxt; // [RL2] [RL5]
    end
  end

  assign gate = st_r;
endmodule

// ==== rtl/adcf_link_shift.sv ====
// serial clock domain: edge counter, output shifter and calibration completion
`timescale 1ns/1ps
module adcf_link_shift (
  // link
  input  wire logic                          sclk,
  input  wire logic                          cs_n,
  // frame state captured at select fall
  input  adcf_pkg::adcf_gate_t               gate,
  // to the pin and the system domain
  output adcf_pkg::adcf_link_t               link
);
  adcf_pkg::adcf_shift_t st_r;
  adcf_pkg::adcf_shift_t st_nxt;
  logic [adcf_pkg::CNT_W-1:0] cnt_inc;

  function automatic logic data_bit(input logic [adcf_pkg::CNT_W-1:0] c,
                                    input logic [adcf_pkg::RES_W-1:0] w);
    logic [adcf_pkg::CNT_W-1:0] idx;
    idx = adcf_pkg::DATA_LAST_EDGE - c;
    data_bit = w[idx[3:0]];
  endfunction

  always_comb begin
    st_nxt  = st_r;
    cnt_inc = (st_r.cnt == adcf_pkg::CNT_MAX) ? st_r.cnt : st_r.cnt + adcf_pkg::CNT_ONE;
    st_nxt.cnt = cnt_inc;
    if (!gate.first && cnt_inc >= adcf_pkg::DATA_FIRST_EDGE && cnt_inc <= adcf_pkg::DATA_LAST_EDGE) begin
      st_nxt.sdo = data_bit(cnt_inc, gate.word); // [RL4] [RL5] [RL19]
    end else begin
      st_nxt.sdo = 1'b0; // [RL6] [RL9]
    end
    // normal calibration runs from edge 17, first-frame calibration ends at edge 16; only a frame that reaches its full length commits
    if (gate.first && cnt_inc == adcf_pkg::CAL_FIRST_EDGES) begin
      st_nxt.cal_done = 1'b1; // [RL10]
    end else if (!gate.first && cnt_inc == adcf_pkg::CAL_NORM_EDGES) begin
      st_nxt.cal_done = 1'b1; // [RL14] [RL15]
    end
  end

  // the link clock stops between frames, so select high clears everything
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      st_r.cnt      <= adcf_pkg::CNT_ZERO;
      st_r.sdo      <= 1'b0;
      st_r.cal_done <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.sdo      = st_r.sdo;
  assign link.cal_done = st_r.cal_done;

  property p_second_zero;
    @(negedge sclk) disable iff (cs_n) st_r.cnt == adcf_pkg::CNT_ONE |-> !st_r.sdo;
  endproperty
  a_second_zero: assert property (p_second_zero) else $error("second lead bit not zero"); // [RL4]

  property p_msb_first;
    @(negedge sclk) disable iff (cs_n)
      (st_r.cnt == adcf_pkg::DATA_FIRST_EDGE && !gate.first) |-> st_r.sdo == gate.word[11];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first data bit is not msb"); // [RL19]

  property p_lsb_last;
    @(negedge sclk) disable iff (cs_n)
      (st_r.cnt == adcf_pkg::DATA_LAST_EDGE && !gate.first) |-> st_r.sdo == gate.word[0];
  endproperty
  a_lsb_last: assert property (p_lsb_last) else $error("lsb not at edge thirteen"); // [RL5]

  property p_tail_low;
    @(negedge sclk) disable iff (cs_n) st_r.cnt >= adcf_pkg::OUT_LOW_EDGE |-> !st_r.sdo;
  endproperty
  a_tail_low: assert property (p_tail_low) else $error("output not low after fourteen clocks"); // [RL6]

  property p_first_low;
    @(negedge sclk) disable iff (cs_n) gate.first |-> !st_r.sdo;
  endproperty
  a_first_low: assert property (p_first_low) else $error("output not low in first frame"); // [RL9]

  property p_no_early_cal;
    @(negedge sclk) disable iff (cs_n)
      (st_r.cnt < adcf_pkg::CAL_FIRST_EDGES || (!gate.first && st_r.cnt < adcf_pkg::CAL_NORM_EDGES))
      |-> !st_r.cal_done;
  endproperty
  a_no_early_cal: assert property (p_no_early_cal) else $error("calibration done too early"); // [RL15]

  property p_norm_cal;
    @(negedge sclk) disable iff (cs_n)
      (!gate.first && st_r.cnt == adcf_pkg::CAL_START_EDGE) ##15 (st_r.cnt == adcf_pkg::CAL_NORM_EDGES)
      |-> st_r.cal_done;
  endproperty
  a_norm_cal: assert property (p_norm_cal) else $error("calibration not done at edge 32"); // [RL14]
endmodule

// ==== rtl/adcf_serial_frame.sv ====
// top of the serial conversion frame block with offset correction
// Operation
// RL1: straight binary, saturating at 000 and FFF
// RL2: select falling opens, rising closes frame
// RL3: host waits setup before first clock fall
// RL4: two zeros, then twelve result bits
// RL5: first zero at select fall, rest on clocks
// RL6: output low after fourteen clocks
// RL7: select rising releases output
// RL8: host gives 200 ns acquisition between frames
// RL9: first frame calibrates, output stays low
// RL10: power-up calibration needs sixteen clocks
// RL11: store clears at power-up, not accessible
// RL12: host gives acquisition after power-up calibration
// RL13: later samples corrected by stored offset
// RL14: normal calibration from clock 17 to 32
// RL15: short frame leaves store unchanged
// RL16: host limits calibration clock rate by supply
// RL17: host gives 15 ns select-to-clock setup
// RL18: host waits 10 ns before raising select
// RL19: result bits go out msb first
`timescale 1ns/1ps
module adcf_serial_frame (
  // system
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // converter core, system domain
  input  wire logic [adcf_pkg::RES_W-1:0]  raw_code,
  input  wire logic [adcf_pkg::RES_W-1:0]  cal_offset,
  // link pins
  input  wire logic                        sclk,
  input  wire logic                        cs_n,
  output      logic                        sdo,
  output      logic                        sdo_oe,
  // status
  output      logic                        offset_loaded,
  output      logic                        sample_ready
);
  adcf_pkg::adcf_top_t  st_r;
  adcf_pkg::adcf_top_t  st_nxt;
  adcf_pkg::adcf_gate_t gate;
  adcf_pkg::adcf_link_t link;
  logic signed [adcf_pkg::DIFF_W-1:0] diff;
  logic [adcf_pkg::RES_W-1:0]         corrected;
  logic                               frame_start;
  logic                               frame_end;
  logic                               cal_rise;

  ////////////////////////////////////////////////////////////////////////////
  // link side

  adcf_frame_gate u_gate (
    .cs_n      (cs_n),
    .first_req (st_r.pending),
    .word_in   (st_r.hold),
    .gate      (gate)
  );

  adcf_link_shift u_shift (
    .sclk (sclk),
    .cs_n (cs_n),
    .gate (gate),
    .link (link)
  );

  assign sdo    = link.sdo;
  assign sdo_oe = gate.oe;

  ////////////////////////////////////////////////////////////////////////////
  // offset correction and saturation

  always_comb begin
    diff = $signed({2'b00, raw_code}) - $signed({{2{st_r.store[11]}}, st_r.store}); // [RL13]
    if (diff < 0) begin
      corrected = adcf_pkg::NEG_FULLSCALE; // [RL1]
    end else if (diff > $signed({2'b00, adcf_pkg::POS_FULLSCALE})) begin
      corrected = adcf_pkg::POS_FULLSCALE; // [RL1]
    end else begin
      corrected = diff[adcf_pkg::RES_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain state

  assign frame_start = st_r.act_s2 && !st_r.act_d;
  assign frame_end   = !st_r.act_s2 && st_r.act_d;
  assign cal_rise    = st_r.cal_s2 && !st_r.cal_d;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.act_s1 = !cs_n;
    st_nxt.act_s2 = st_r.act_s1;
    st_nxt.act_d  = st_r.act_s2;
    st_nxt.cal_s1 = link.cal_done;
    st_nxt.cal_s2 = st_r.cal_s1;
    st_nxt.cal_d  = st_r.cal_s2;
    if (frame_start) begin
      st_nxt.pending = 1'b0; // [RL9]
    end
    // the completion level only rises after the full clock count, so a short
    // frame never reaches this and the store keeps its value
    if (cal_rise) begin
      st_nxt.store  = cal_offset; // [RL10] [RL15]
      st_nxt.loaded = 1'b1;
    end
    // publish a new word only once the acquisition window has run after a frame;
    // the host must keep select high at least that long or it may catch the update
    if (st_r.act_s2) begin
      st_nxt.acq_cnt = adcf_pkg::ACQ_ZERO;
      st_nxt.ready   = 1'b0;
    end else if (frame_end) begin
      st_nxt.acq_cnt = adcf_pkg::ACQ_ZERO;
      st_nxt.ready   = 1'b0;
    end else if (st_r.acq_cnt != adcf_pkg::ACQ_LAST) begin
      st_nxt.acq_cnt = st_r.acq_cnt + 5'h01;
    end else begin
      st_nxt.ready = 1'b1;
      st_nxt.hold  = corrected; // [RL13]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r         <= '0;
      st_r.pending <= 1'b1; // [RL9]
      st_r.store   <= adcf_pkg::STORE_RESET; // [RL11]
      st_r.hold    <= adcf_pkg::MIDSCALE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign offset_loaded = st_r.loaded;
  assign sample_ready  = st_r.ready;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_cal_seen;
    st_r.cal_s2 && !st_r.cal_d;
  endsequence

  sequence s_publish;
    !st_r.act_s2 && !frame_end && st_r.acq_cnt == adcf_pkg::ACQ_LAST;
  endsequence

  property p_store_reset;
    @(posedge clk) sys_rst |=> st_r.store == adcf_pkg::STORE_RESET && st_r.pending;
  endproperty
  a_store_reset: assert property (p_store_reset) else $error("store not cleared at power-up"); // [RL11]

  property p_store_load;
    @(posedge clk) disable iff (sys_rst) s_cal_seen |=> st_r.store == $past(cal_offset) && st_r.loaded;
  endproperty
  a_store_load: assert property (p_store_load) else $error("store not loaded on calibration"); // [RL10]

  property p_store_kept;
    @(posedge clk) disable iff (sys_rst) !cal_rise |=> $stable(st_r.store);
  endproperty
  a_store_kept: assert property (p_store_kept) else $error("store changed without calibration"); // [RL15]

  property p_midscale;
    @(posedge clk) disable iff (sys_rst)
      (s_publish and (raw_code == adcf_pkg::MIDSCALE && st_r.store == adcf_pkg::STORE_RESET))
      |=> st_r.hold == adcf_pkg::MIDSCALE;
  endproperty
  a_midscale: assert property (p_midscale) else $error("mid code not preserved"); // [RL1]

  property p_corrected;
    @(posedge clk) disable iff (sys_rst) s_publish |=> st_r.hold == $past(corrected) && st_r.ready;
  endproperty
  a_corrected: assert property (p_corrected) else $error("corrected word not published"); // [RL13]

  property p_hold_frozen;
    @(posedge clk) disable iff (sys_rst) st_r.act_s2 |=> $stable(st_r.hold);
  endproperty
  a_hold_frozen: assert property (p_hold_frozen) else $error("word changed inside a frame"); // [RL2]

  property p_release;
    @(posedge clk) disable iff (sys_rst) cs_n |-> !sdo_oe;
  endproperty
  a_release: assert property (p_release) else $error("output driven with select high"); // [RL7]

  ////////////////////////////////////////////////////////////////////////////
  // publication and status checks

  sequence s_frame_open;
    st_r.act_s2 && !st_r.act_d;
  endsequence

  sequence s_frame_close;
    !st_r.act_s2 && st_r.act_d;
  endsequence

  property p_pending_clear;
    @(posedge clk) disable iff (sys_rst)
      s_frame_open |=> !st_r.pending;
  endproperty
  a_pending_clear: assert property (p_pending_clear) else $error("first flag kept"); // [RL9]

  property p_pending_kept;
    @(posedge clk) disable iff (sys_rst)
      (st_r.pending && !frame_start) |=> st_r.pending;
  endproperty
  a_pending_kept: assert property (p_pending_kept) else $error("first flag lost"); // [RL9]

  property p_loaded_sticky;
    @(posedge clk) disable iff (sys_rst)
      offset_loaded |=> offset_loaded;
  endproperty
  a_loaded_sticky: assert property (p_loaded_sticky) else $error("loaded flag dropped"); // [RL10]

  property p_loaded_needs_cal;
    @(posedge clk) disable iff (sys_rst)
      (!offset_loaded && !cal_rise) |=> !offset_loaded;
  endproperty
  a_loaded_needs_cal: assert property (p_loaded_needs_cal) else $error("loaded without calibration"); // [RL15]

  property p_acq_restart;
    @(posedge clk) disable iff (sys_rst)
      s_frame_close |=> st_r.acq_cnt == adcf_pkg::ACQ_ZERO && !sample_ready;
  endproperty
  a_acq_restart: assert property (p_acq_restart) else $error("window not restarted"); // [RL2]

  property p_in_frame_idle;
    @(posedge clk) disable iff (sys_rst)
      st_r.act_s2 |=> st_r.acq_cnt == adcf_pkg::ACQ_ZERO && !sample_ready;
  endproperty
  a_in_frame_idle: assert property (p_in_frame_idle) else $error("ready inside a frame"); // [RL2]

  property p_acq_step;
    @(posedge clk) disable iff (sys_rst)
      (!st_r.act_s2 && !frame_end && st_r.acq_cnt != adcf_pkg::ACQ_LAST)
      |=> st_r.acq_cnt == $past(st_r.acq_cnt) + 5'h01 && !sample_ready;
  endproperty
  a_acq_step: assert property (p_acq_step) else $error("window count skipped"); // [RL13]

  property p_acq_bound;
    @(posedge clk) disable iff (sys_rst) st_r.acq_cnt <= adcf_pkg::ACQ_LAST;
  endproperty
  a_acq_bound: assert property (p_acq_bound) else $error("window count out of range"); // [RL13]

  property p_ready_stays;
    @(posedge clk) disable iff (sys_rst)
      (sample_ready && !st_r.act_s2) |=> sample_ready;
  endproperty
  a_ready_stays: assert property (p_ready_stays) else $error("ready dropped while idle"); // [RL13]

  property p_ready_late;
    @(posedge clk) disable iff (sys_rst)
      $rose(sample_ready) |-> $past(st_r.acq_cnt) == adcf_pkg::ACQ_LAST;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too early"); // [RL13]

  property p_hold_only_publish;
    @(posedge clk) disable iff (sys_rst)
      (st_r.acq_cnt != adcf_pkg::ACQ_LAST) |=> $stable(st_r.hold);
  endproperty
  a_hold_only_publish: assert property (p_hold_only_publish) else $error("word changed early"); // [RL13]

  property p_sat_low;
    @(posedge clk) disable iff (sys_rst)
      (s_publish ##0 diff[adcf_pkg::DIFF_W-1]) |=> st_r.hold == adcf_pkg::NEG_FULLSCALE;
  endproperty
  a_sat_low: assert property (p_sat_low) else $error("negative result not clamped"); // [RL1]

  property p_sat_high;
    @(posedge clk) disable iff (sys_rst)
      (s_publish ##0 (!diff[adcf_pkg::DIFF_W-1] && diff[adcf_pkg::RES_W])) |=> st_r.hold == adcf_pkg::POS_FULLSCALE;
  endproperty
  a_sat_high: assert property (p_sat_high) else $error("overflow not clamped"); // [RL1]

  property p_bottom_code;
    @(posedge clk) disable iff (sys_rst)
      (s_publish ##0 (raw_code == adcf_pkg::NEG_FULLSCALE && st_r.store == adcf_pkg::STORE_RESET))
      |=> st_r.hold == adcf_pkg::NEG_FULLSCALE;
  endproperty
  a_bottom_code: assert property (p_bottom_code) else $error("bottom code not kept"); // [RL1]

  property p_zero_offset;
    @(posedge clk) disable iff (sys_rst)
      (s_publish ##0 (st_r.store == adcf_pkg::STORE_RESET)) |=> st_r.hold == $past(raw_code);
  endproperty
  a_zero_offset: assert property (p_zero_offset) else $error("word altered by empty store"); // [RL11]

  // raw select on purpose: both link flops act on its edges with no sync between
  property p_oe_in_frame;
    @(posedge clk) disable iff (sys_rst) !cs_n |-> sdo_oe;
  endproperty
  a_oe_in_frame: assert property (p_oe_in_frame) else $error("output idle inside a frame"); // [RL5]

  property p_sdo_idle;
    @(posedge clk) disable iff (sys_rst) cs_n |-> !sdo;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("serial output high with select high"); // [RL7]

  property p_reset_view;
    @(posedge clk)
      $fell(sys_rst) |-> st_r.hold == adcf_pkg::MIDSCALE && !offset_loaded && !sample_ready;
  endproperty
  a_reset_view: assert property (p_reset_view) else $error("state wrong after power-up"); // [RL11]
endmodule

// ==== test/adcf_host_model.sv ====
// host side model: frames the link with select and serial clock, captures the serial output
`timescale 1ns/1ps
module adcf_host_model (
  // link
  output logic       cs_n,
  output logic       sclk,
  input  wire logic  sdo,
  input  wire logic  sdo_oe
);
  // the link flops know no reset but select high, so one short pulse at power-up
  // gives the enable and shifter flops a known state before the first real frame
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    #1;
    cs_n = 1'b0;
    #1;
    cs_n = 1'b1;
  end
  // one frame of n falling clock edges; the clock stands parked high outside frames
  // half >= 31.25 ns keeps the rate at or below 16 MHz in calibration frames
  task automatic frame(input int n, input realtime half, output logic [13:0] bits,
                       output logic late_high, output logic oe_ok, output logic [1:0] rel);
    bits = 14'h0000;
    late_high = 1'b0;
    #7;
    cs_n = 1'b0;
    #20; // select-to-clock setup, above 15 ns
    bits = {bits[12:0], sdo};
    oe_ok = sdo_oe;
    for (int i = 1; i <= n; i++) begin
      sclk = 1'b0;
      #(half);
      sclk = 1'b1; // sample mid bit, half a period after the launching fall
      if (i < 14) bits = {bits[12:0], sdo};
      else if (sdo !== 1'b0) late_high = 1'b1;
      oe_ok = oe_ok & sdo_oe;
      #(half); // last fall to deselect well above 10 ns
    end
    cs_n = 1'b1;
    #5;
    rel = {sdo_oe, sdo};
    #250; // acquisition window plus sync margin before any next frame
  endtask
endmodule

// ==== test/adcf_serial_frame_tb_top.sv ====
// self-checking bench for the serial conversion frame block
`timescale 1ns/1ps
module adcf_serial_frame_tb_top;
  logic        clk;
  logic        sys_rst;
  logic [11:0] raw_code;
  logic [11:0] cal_offset;
  wire         sclk;
  wire         cs_n;
  wire         sdo;
  wire         sdo_oe;
  wire         offset_loaded;
  wire         sample_ready;
  int          err_count = 0;
  int          comparisons = 0;

  adcf_serial_frame dut_u (.clk(clk), .sys_rst(sys_rst), .raw_code(raw_code), .cal_offset(cal_offset),
    .sclk(sclk), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe), .offset_loaded(offset_loaded),
    .sample_ready(sample_ready));
  adcf_host_model host_u (.cs_n(cs_n), .sclk(sclk), .sdo(sdo), .sdo_oe(sdo_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // expected corrected word: signed offset removed, clamped to the code range
  function automatic logic [11:0] corr(input logic [11:0] raw, input logic [11:0] off);
    int v;
    v = int'(raw) - int'($signed(off));
    if (v < 0) v = 0;
    if (v > 4095) v = 4095;
    return v[11:0];
  endfunction

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (8) tick();
    sys_rst = 1'b0;
    tick();
  endtask

  // data frame after the acquisition window; checks word, trailing zeros, enable and release
  task automatic dframe(input int n, input realtime half, input logic [11:0] raw, input logic [11:0] exp);
    logic [13:0] bits;
    logic        late;
    logic        oe_ok;
    logic [1:0]  rel;
    int          k;
    raw_code = raw;
    repeat (adcf_pkg::ACQ_CYC) tick();
    k = 0;
    while (sample_ready !== 1'b1 && k < 40) begin
      tick();
      k++;
    end
    chk(sample_ready, 1'b1);
    repeat (3) tick();
    host_u.frame(n, half, bits, late, oe_ok, rel);
    chk(bits, {2'b00, exp});
    chk(late, 1'b0);
    chk(oe_ok, 1'b1);
    chk(rel, 2'b00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_state();
    chk({offset_loaded, sample_ready, sdo_oe}, 3'b000);
    $display("reset state done");
  endtask

  task automatic t_short_first();
    logic [13:0] bits;
    logic        late;
    logic        oe_ok;
    logic [1:0]  rel;
    cal_offset = 12'h0FF;
    host_u.frame(10, 80.0, bits, late, oe_ok, rel);
    chk(bits, 14'h0000);
    repeat (10) tick();
    chk(offset_loaded, 1'b0);
    dframe(16, 80.0, 12'h123, 12'h123);
    dframe(16, 80.0, 12'h800, 12'h800);
    $display("short first frame done");
  endtask

  task automatic t_first_cal();
    logic [13:0] bits;
    logic        late;
    logic        oe_ok;
    logic [1:0]  rel;
    do_reset();
    cal_offset = 12'h005;
    host_u.frame(16, 80.0, bits, late, oe_ok, rel);
    chk({bits, late}, 15'h0000);
    chk(rel, 2'b00);
    repeat (6) tick();
    chk(offset_loaded, 1'b1);
    $display("power-up calibration done");
  endtask

  task automatic t_corrected();
    logic [11:0] raws [4] = '{12'h805, 12'h003, 12'hFFF, 12'h000};
    // one edge past 32 so the link check can see the completed calibration
    foreach (raws[i]) dframe(33, 80.0, raws[i], corr(raws[i], 12'h005));
    $display("corrected words done");
  endtask

  task automatic t_normal_cal();
    cal_offset = 12'hFFE;
    dframe(31, 80.0, 12'h010, 12'h00B);
    dframe(16, 80.0, 12'h805, 12'h800);
    dframe(32, 120.0, 12'h010, 12'h00B);
    dframe(16, 80.0, 12'hFFE, 12'hFFF);
    dframe(16, 80.0, 12'h805, corr(12'h805, 12'hFFE));
    $display("normal calibration done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    raw_code = 12'h000;
    cal_offset = 12'h000;
    do_reset();
    t_reset_state();
    t_short_first();
    t_first_cal();
    t_corrected();
    t_normal_cal();
    report_and_stop();
  end

  // whole run needs well under 150 us; a hang is cut short at 400 us
  initial begin
    #400000;
    err_count++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    report_and_stop();
  end
endmodule
